// [rtl/sptb_uart.sv]
// Contract
// - Mode 00 is synchronous eight-bit shift mode
// - Sync mode: data on rx pin, clock on tx
// - Sync frames are eight bits, LSB first
// - Mode 01: start, eight data, stop bit
// - Mode 11: start, eight data, ninth, stop
// - Mode 11 filter: flag only if ninth set
// - Sync rate: sysclk/12, or /4 when selected
// - Receive only while receive enable is set
// - Mode 11 sends tx_ninth_bit as ninth bit
// - Mode 11 stores received ninth bit
// - Done flags set by hardware, software clears
// - Buffer write loads shifter, starts frame
// - Buffer read returns separate receive latch
// - Async port clock optionally divided by 16
// - Timer 1 reload divides when selects clear
// - Timer 2 capture pair divides if selected
// - Mode 10 is reserved, does nothing
`timescale 1ns/1ps
`default_nettype none
module sptb_uart #(
    parameter int ADDR_W = 12
) (
    input  wire logic              mclk_i,
    input  wire logic              sys_rst_i,
    input  wire logic [ADDR_W-1:0] awaddr_i,
    input  wire logic              awvalid_i,
    output logic                   awready_o,
    input  wire logic [31:0]       wdata_i,
    input  wire logic [3:0]        wstrb_i,
    input  wire logic              wvalid_i,
    output logic                   wready_o,
    output logic [1:0]             bresp_o,
    output logic                   bvalid_o,
    input  wire logic              bready_i,
    input  wire logic [ADDR_W-1:0] araddr_i,
    input  wire logic              arvalid_i,
    output logic                   arready_o,
    output logic [31:0]            rdata_o,
    output logic [1:0]             rresp_o,
    output logic                   rvalid_o,
    input  wire logic              rready_i,
    input  wire logic              rxd_i,
    output logic                   rxd_o,
    output logic                   rxd_oe_n_o,
    output logic                   txd_o
);
    // =========================================================
    // State
    typedef struct packed {
        logic                          awrdy;
        logic                          wrdy;
        logic [sptb_pkg::IDX_W-1:0]    widx;
        logic [7:0]                    wdat;
        logic                          wstb;
        logic                          bvalid;
        logic [1:0]                    bresp;
        logic                          arrdy;
        logic                          rvalid;
        logic [1:0]                    rresp;
        logic [7:0]                    rdata;
        logic [7:0]                    serial_control;
        logic [7:0]                    rx_latch;
        logic                          rate_divide_select;
        logic [7:0]                    t1l;
        logic [7:0]                    t1h;
        logic [7:0]                    t2c;
        logic [7:0]                    t2l;
        logic [7:0]                    t2h;
        logic                          sync1;
        logic                          sync2;
        logic                          rx_prev;
        sptb_pkg::sptb_tx_t            tstate;
        logic                          m0rx;
        logic [19:0]                   tcnt;
        logic [3:0]                    tbits;
        logic [9:0]                    tshift;
        logic [7:0]                    m0sh;
        logic                          txd;
        logic                          rxd_out;
        logic                          rxd_oe_n;
        sptb_pkg::sptb_rx_t            rstate;
        logic [19:0]                   rcnt;
        logic [3:0]                    rbits;
        logic [8:0]                    rshift;
    } sptb_state_t;

    sptb_state_t r_reg;
    sptb_state_t r_next;
    logic [1:0]  mode;
    logic [15:0] divisor;
    logic [19:0] blen;
    logic [19:0] slen;
    logic [19:0] tlen;
    logic        serial_buffer_wr;
    logic        serial_control_wr;
    logic        wr_go;
    logic        tx_fin;
    logic        rx_fin;
    logic        rx_keep;
    logic        ar_go;

    assign awready_o  = r_reg.awrdy;
    assign wready_o   = r_reg.wrdy;
    assign bvalid_o   = r_reg.bvalid;
    assign bresp_o    = r_reg.bresp;
    assign arready_o  = r_reg.arrdy;
    assign rvalid_o   = r_reg.rvalid;
    assign rresp_o    = r_reg.rresp;
    assign rdata_o    = {24'h000000, r_reg.rdata};
    assign rxd_o      = r_reg.rxd_out;
    assign rxd_oe_n_o = r_reg.rxd_oe_n;
    assign txd_o      = r_reg.txd;

    // =========================================================
    // Next state
    always_comb
    begin
        r_next  = r_reg;
        serial_buffer_wr = 1'b0;
        serial_control_wr = 1'b0;
        tx_fin  = 1'b0;
        rx_fin  = 1'b0;
        rx_keep = 1'b0;
        mode    = r_reg.serial_control[sptb_pkg::SC_MODE -: 2];
        // Mode 10 matches no case below, so it never starts a frame
        if (r_reg.t2c[sptb_pkg::T2_TIMER2_TX_CLOCK_SELECT] || r_reg.t2c[sptb_pkg::T2_RCLK])
            divisor = {r_reg.t2h, r_reg.t2l};
        else
            divisor = {r_reg.t1h, r_reg.t1l};
        blen = r_reg.rate_divide_select ? {divisor, 4'h0} : {4'h0, divisor};
        slen = r_reg.serial_control[sptb_pkg::SC_SM2] ? sptb_pkg::SYNC_DIV_FAST
                                            : sptb_pkg::SYNC_DIV_SLOW;
        tlen = (mode == sptb_pkg::MODE_SYNC) ? slen : blen;

        r_next.sync1   = rxd_i;
        r_next.sync2   = r_reg.sync1;
        r_next.rx_prev = r_reg.sync2;

        // =====================================================
        // Bus slave: address and data accepted in either order
        if (r_reg.awrdy && awvalid_i)
        begin
            r_next.awrdy = 1'b0;
            r_next.widx  = awaddr_i[ADDR_W-1:2];
        end
        if (r_reg.wrdy && wvalid_i)
        begin
            r_next.wrdy = 1'b0;
            r_next.wdat = wdata_i[7:0];
            r_next.wstb = wstrb_i[0];
        end
        wr_go = !r_reg.awrdy && !r_reg.wrdy && !r_reg.bvalid;
        if (wr_go)
        begin
            r_next.bvalid = 1'b1;
            r_next.bresp  = sptb_pkg::RESP_OKAY;
            case (r_reg.widx)
                sptb_pkg::IDX_PWR:  if (r_reg.wstb) r_next.rate_divide_select = r_reg.wdat[sptb_pkg::PW_RATE_DIVIDE_SELECT];
                sptb_pkg::IDX_SERIAL_CONTROL: if (r_reg.wstb) r_next.serial_control = r_reg.wdat;
                sptb_pkg::IDX_SERIAL_BUFFER: serial_buffer_wr = r_reg.wstb;
                sptb_pkg::IDX_T1L:  if (r_reg.wstb) r_next.t1l = r_reg.wdat;
                sptb_pkg::IDX_T1H:  if (r_reg.wstb) r_next.t1h = r_reg.wdat;
                sptb_pkg::IDX_T2C:  if (r_reg.wstb) r_next.t2c = r_reg.wdat;
                sptb_pkg::IDX_T2L:  if (r_reg.wstb) r_next.t2l = r_reg.wdat;
                sptb_pkg::IDX_T2H:  if (r_reg.wstb) r_next.t2h = r_reg.wdat;
                default:            r_next.bresp = sptb_pkg::RESP_SLVERR;
            endcase
            serial_control_wr = r_reg.wstb && (r_reg.widx == sptb_pkg::IDX_SERIAL_CONTROL);
        end
        if (r_reg.bvalid && bready_i)
        begin
            r_next.bvalid = 1'b0;
            r_next.awrdy  = 1'b1;
            r_next.wrdy   = 1'b1;
        end
        ar_go = r_reg.arrdy && arvalid_i;
        if (ar_go)
        begin
            r_next.arrdy  = 1'b0;
            r_next.rvalid = 1'b1;
            r_next.rresp  = sptb_pkg::RESP_OKAY;
            case (araddr_i[ADDR_W-1:2])
                sptb_pkg::IDX_PWR:  r_next.rdata = sptb_pkg::RST_BYTE; // Write-only
                sptb_pkg::IDX_SERIAL_CONTROL: r_next.rdata = r_reg.serial_control;
                sptb_pkg::IDX_SERIAL_BUFFER: r_next.rdata = r_reg.rx_latch;
                sptb_pkg::IDX_T1L:  r_next.rdata = r_reg.t1l;
                sptb_pkg::IDX_T1H:  r_next.rdata = r_reg.t1h;
                sptb_pkg::IDX_T2C:  r_next.rdata = r_reg.t2c;
                sptb_pkg::IDX_T2L:  r_next.rdata = r_reg.t2l;
                sptb_pkg::IDX_T2H:  r_next.rdata = r_reg.t2h;
                default:
                begin
                    r_next.rdata = sptb_pkg::RST_BYTE;
                    r_next.rresp = sptb_pkg::RESP_SLVERR;
                end
            endcase
        end
        if (r_reg.rvalid && rready_i)
        begin
            r_next.rvalid = 1'b0;
            r_next.arrdy  = 1'b1;
        end

        // =====================================================
        // Transmitter, also the shift engine of synchronous mode
        case (r_reg.tstate)
            sptb_pkg::T_IDLE:
            begin
                if (serial_buffer_wr && mode == sptb_pkg::MODE_SYNC)
                begin
                    r_next.tstate   = sptb_pkg::T_RUN;
                    r_next.m0rx     = 1'b0;
                    r_next.tcnt     = 20'h00000;
                    r_next.tbits    = 4'h0;
                    r_next.rxd_out  = r_reg.wdat[0];
                    r_next.tshift   = {3'b111, r_reg.wdat[7:1]};
                    r_next.rxd_oe_n = 1'b0;
                    r_next.txd      = 1'b0;
                end
                else if (serial_buffer_wr && mode[0])
                begin
                    r_next.tstate = sptb_pkg::T_RUN;
                    r_next.tcnt   = 20'h00000;
                    r_next.tbits  = 4'h0;
                    r_next.txd    = 1'b0;
                    r_next.tshift = {1'b1, mode[1] ? r_reg.serial_control[sptb_pkg::SC_TB8]
                                                   : 1'b1, r_reg.wdat};
                end
                else if (mode == sptb_pkg::MODE_SYNC && r_reg.serial_control[sptb_pkg::SC_REN]
                         && !r_reg.serial_control[sptb_pkg::SC_RI] && !wr_go)
                begin
                    r_next.tstate   = sptb_pkg::T_RUN;
                    r_next.m0rx     = 1'b1;
                    r_next.tcnt     = 20'h00000;
                    r_next.tbits    = 4'h0;
                    r_next.rxd_oe_n = 1'b1;
                    r_next.txd      = 1'b0;
                end
            end
            sptb_pkg::T_RUN:
            begin
                r_next.tcnt = r_reg.tcnt + 20'h00001;
                if (mode == sptb_pkg::MODE_SYNC && r_reg.tcnt == (tlen >> 1) - 20'h00001)
                begin
                    r_next.txd = 1'b1;
                    if (r_reg.m0rx)
                        r_next.m0sh = {r_reg.sync2, r_reg.m0sh[7:1]};
                end
                if (r_reg.tcnt >= tlen - 20'h00001)
                begin
                    r_next.tcnt  = 20'h00000;
                    r_next.tbits = r_reg.tbits + 4'h1;
                    if (mode == sptb_pkg::MODE_SYNC)
                    begin
                        if (r_reg.tbits == sptb_pkg::BITS_SYNC - 4'h1)
                        begin
                            r_next.tstate   = sptb_pkg::T_IDLE;
                            r_next.rxd_oe_n = 1'b1;
                            if (r_reg.m0rx)
                                rx_keep = 1'b1;
                            else
                                tx_fin = 1'b1;
                        end
                        else
                        begin
                            r_next.txd     = 1'b0;
                            r_next.rxd_out = r_reg.tshift[0];
                            r_next.tshift  = {1'b1, r_reg.tshift[9:1]};
                        end
                    end
                    else if (r_reg.tbits == (mode[1] ? sptb_pkg::LAST_A11
                                                     : sptb_pkg::LAST_A10))
                    begin
                        r_next.tstate = sptb_pkg::T_IDLE;
                        tx_fin        = 1'b1;
                    end
                    else
                    begin
                        r_next.txd    = r_reg.tshift[0];
                        r_next.tshift = {1'b1, r_reg.tshift[9:1]};
                    end
                end
            end
            default: r_next.tstate = sptb_pkg::T_IDLE;
        endcase
        if (r_reg.tstate == sptb_pkg::T_RUN && !mode[0] && mode != sptb_pkg::MODE_SYNC)
        begin
            // Software moved to the reserved mode mid-frame: abandon it
            r_next.tstate   = sptb_pkg::T_IDLE;
            r_next.txd      = 1'b1;
            r_next.rxd_oe_n = 1'b1;
        end

        // =====================================================
        // Asynchronous receiver
        case (r_reg.rstate)
            sptb_pkg::R_IDLE:
                if (r_reg.rx_prev && !r_reg.sync2)
                begin
                    r_next.rstate = sptb_pkg::R_START;
                    r_next.rcnt   = 20'h00000;
                end
            sptb_pkg::R_START:
            begin
                r_next.rcnt = r_reg.rcnt + 20'h00001;
                if (r_reg.rcnt >= (blen >> 1) - 20'h00001)
                begin
                    // A glitch shorter than half a bit is not a start bit
                    r_next.rstate = r_reg.sync2 ? sptb_pkg::R_IDLE : sptb_pkg::R_DATA;
                    r_next.rcnt   = 20'h00000;
                    r_next.rbits  = 4'h0;
                end
            end
            sptb_pkg::R_DATA:
            begin
                r_next.rcnt = r_reg.rcnt + 20'h00001;
                if (r_reg.rcnt >= blen - 20'h00001)
                begin
                    r_next.rcnt = 20'h00000;
                    if (r_reg.rbits == (mode[1] ? sptb_pkg::BITS_A11 : sptb_pkg::BITS_A10))
                    begin
                        r_next.rstate = sptb_pkg::R_IDLE;
                        rx_fin        = 1'b1;
                    end
                    else
                    begin
                        r_next.rbits  = r_reg.rbits + 4'h1;
                        r_next.rshift = {r_reg.sync2, r_reg.rshift[8:1]};
                    end
                end
            end
            default: r_next.rstate = sptb_pkg::R_IDLE;
        endcase
        if (!r_reg.serial_control[sptb_pkg::SC_REN] || !mode[0])
            r_next.rstate = sptb_pkg::R_IDLE;

        // =====================================================
        // Hardware flag updates come last so a set beats a clear
        if (rx_fin)
        begin
            if (mode[1])
            begin
                if (!r_reg.serial_control[sptb_pkg::SC_SM2] || r_reg.rshift[8])
                begin
                    r_next.rx_latch                 = r_reg.rshift[7:0];
                    r_next.serial_control[sptb_pkg::SC_RB8] = r_reg.rshift[8];
                    r_next.serial_control[sptb_pkg::SC_RI]  = 1'b1;
                end
            end
            else
            begin
                r_next.rx_latch                = r_reg.rshift[8:1];
                r_next.serial_control[sptb_pkg::SC_RI] = 1'b1;
            end
        end
        if (rx_keep)
        begin
            r_next.rx_latch                = r_reg.m0sh;
            r_next.serial_control[sptb_pkg::SC_RI] = 1'b1;
        end
        if (tx_fin)
        begin
            r_next.txd                     = 1'b1;
            r_next.serial_control[sptb_pkg::SC_TI] = 1'b1;
        end
    end

    // =========================================================
    // Registers
    always_ff @(posedge mclk_i)
    begin
        if (sys_rst_i)
        begin
            r_reg          <= '0;
            r_reg.awrdy    <= 1'b1;
            r_reg.wrdy     <= 1'b1;
            r_reg.arrdy    <= 1'b1;
            r_reg.sync1    <= 1'b1;
            r_reg.sync2    <= 1'b1;
            r_reg.rx_prev  <= 1'b1;
            r_reg.txd      <= 1'b1;
            r_reg.rxd_out  <= 1'b1;
            r_reg.rxd_oe_n <= 1'b1;
        end
        else
            r_reg <= r_next;
    end

    // =========================================================
    // Checks
    AST_RSV_IDLE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        serial_buffer_wr && mode == sptb_pkg::MODE_RSV && r_reg.tstate == sptb_pkg::T_IDLE
        |=> r_reg.tstate == sptb_pkg::T_IDLE)
        else $error("reserved mode started a frame");
    AST_REN_OFF: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !r_reg.serial_control[sptb_pkg::SC_REN] |=> r_reg.rstate == sptb_pkg::R_IDLE)
        else $error("receiver active while disabled");
    AST_START_BIT: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        serial_buffer_wr && mode == sptb_pkg::MODE_A10 && r_reg.tstate == sptb_pkg::T_IDLE
        |=> !txd_o && r_reg.tstate == sptb_pkg::T_RUN)
        else $error("buffer write did not start a frame");
    AST_TI_SET: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        tx_fin |=> r_reg.serial_control[sptb_pkg::SC_TI] && txd_o)
        else $error("transmit flag not raised");
    AST_TI_STICKY: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        r_reg.serial_control[sptb_pkg::SC_TI] && !serial_control_wr |=> r_reg.serial_control[sptb_pkg::SC_TI])
        else $error("transmit flag cleared by hardware");
    AST_FILTER: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        rx_fin && mode == sptb_pkg::MODE_A11 && r_reg.serial_control[sptb_pkg::SC_SM2]
        && !r_reg.rshift[8] && !r_reg.serial_control[sptb_pkg::SC_RI] && !serial_control_wr
        |=> !r_reg.serial_control[sptb_pkg::SC_RI])
        else $error("filtered frame raised receive flag");
    AST_SYNC_DRIVE: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        r_reg.tstate == sptb_pkg::T_RUN && mode == sptb_pkg::MODE_SYNC && !r_reg.m0rx
        |-> !rxd_oe_n_o)
        else $error("sync transmit not driving data pin");
    AST_SYNC_LSB: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        serial_buffer_wr && mode == sptb_pkg::MODE_SYNC && r_reg.tstate == sptb_pkg::T_IDLE
        |=> rxd_o == $past(r_reg.wdat[0]) && !txd_o)
        else $error("sync frame not LSB first");
    AST_B_HOLD: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
        else $error("write response dropped");
    COV_TX: cover property (@(posedge mclk_i) disable iff (sys_rst_i) tx_fin);
    COV_RX: cover property (@(posedge mclk_i) disable iff (sys_rst_i) rx_fin);
    COV_M0RX: cover property (@(posedge mclk_i) disable iff (sys_rst_i) rx_keep);
endmodule : sptb_uart
`default_nettype wire

// [rtl/sptb_pkg.sv]
package sptb_pkg;
    // =========================================================
    // Register indices (byte address is four times the index)
    localparam int             IDX_W    = 10;
    localparam logic [IDX_W-1:0] IDX_PWR  = 10'h087;
    localparam logic [IDX_W-1:0] IDX_SERIAL_CONTROL = 10'h098;
    localparam logic [IDX_W-1:0] IDX_SERIAL_BUFFER = 10'h099;
    localparam logic [IDX_W-1:0] IDX_T1L  = 10'h08a;
    localparam logic [IDX_W-1:0] IDX_T1H  = 10'h08b;
    localparam logic [IDX_W-1:0] IDX_T2C  = 10'h0c8;
    localparam logic [IDX_W-1:0] IDX_T2L  = 10'h0ca;
    localparam logic [IDX_W-1:0] IDX_T2H  = 10'h0cb;
    // =========================================================
    // Field positions and reset values
    localparam int        SC_RI   = 0;
    localparam int        SC_TI   = 1;
    localparam int        SC_RB8  = 2;
    localparam int        SC_TB8  = 3;
    localparam int        SC_REN  = 4;
    localparam int        SC_SM2  = 5;
    localparam int        SC_MODE = 7;
    localparam int        PW_RATE_DIVIDE_SELECT = 7;
    localparam int        T2_TIMER2_TX_CLOCK_SELECT = 4;
    localparam int        T2_RCLK = 5;
    localparam logic [7:0] RST_BYTE = 8'h00;
    // =========================================================
    // Modes, rates and frame lengths
    localparam logic [1:0] MODE_SYNC = 2'b00;
    localparam logic [1:0] MODE_A10  = 2'b01;
    localparam logic [1:0] MODE_RSV  = 2'b10;
    localparam logic [1:0] MODE_A11  = 2'b11;
    localparam logic [19:0] SYNC_DIV_SLOW = 20'h0000c;
    localparam logic [19:0] SYNC_DIV_FAST = 20'h00004;
    localparam logic [3:0] BITS_SYNC = 4'h8;
    localparam logic [3:0] BITS_A10  = 4'h8;
    localparam logic [3:0] BITS_A11  = 4'h9;
    localparam logic [3:0] LAST_A10  = 4'h9;
    localparam logic [3:0] LAST_A11  = 4'ha;
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [0:0] {T_IDLE, T_RUN} sptb_tx_t;
    typedef enum logic [1:0] {R_IDLE, R_START, R_DATA} sptb_rx_t;
endpackage : sptb_pkg

// [tb/sptb_serial_dev.sv]
`timescale 1ns/1ps
`default_nettype none
// ========================================
// Far-side serial device, asynchronous frames only
module sptb_serial_dev #(
    parameter int L = 17
) (
    input  wire logic       mclk_i,
    input  wire logic       txd_i,
    output logic            rxd_o,
    output logic [8:0]      got_o
);
    // Nine samples: the last is the ninth bit, or the stop bit in ten-bit frames
    initial
    begin
        rxd_o = 1'b1;
        got_o = 9'h000;
        forever
        begin
            @(negedge txd_i);
            repeat (L / 2) @(posedge mclk_i);
            for (int k = 0; k < 9; k++)
            begin
                repeat (L) @(posedge mclk_i);
                got_o[k] = txd_i;
            end
        end
    end
    task automatic send(input logic [8:0] v, input int n);
        @(posedge mclk_i);
        rxd_o <= 1'b0;
        for (int k = 0; k <= n; k++)
        begin
            repeat (L) @(posedge mclk_i);
            rxd_o <= (k == n) ? 1'b1 : v[k];
        end
        repeat (L) @(posedge mclk_i);
    endtask : send
endmodule : sptb_serial_dev
`default_nettype wire

// [tb/sptb_uart_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module sptb_uart_bench;
    logic        mclk_i = 1'b0, sys_rst_i = 1'b1;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, txd, rxd_o, oe_n, dev_rxd;
    logic [1:0]  bresp, rresp, r;
    logic [7:0]  d;
    logic [8:0]  got;
    int          fail_count = 0, cmp_count = 0;
    wire logic   rxd_line = oe_n ? dev_rxd : rxd_o;
    sptb_uart u_sptb_uart (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .awaddr_i(awaddr),
        .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata), .wstrb_i(4'h1),
        .wvalid_i(wvalid), .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid),
        .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready),
        .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid), .rready_i(rready),
        .rxd_i(rxd_line), .rxd_o(rxd_o), .rxd_oe_n_o(oe_n), .txd_o(txd));
    sptb_serial_dev u_sptb_serial_dev (.mclk_i(mclk_i), .txd_i(txd), .rxd_o(dev_rxd),
        .got_o(got));
    // ========================================
    // Bus tasks
    task automatic wr(input logic [9:0] i, input logic [7:0] v);
        @(posedge mclk_i);
        awaddr <= {i, 2'b00};
        wdata <= {24'h000000, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge mclk_i);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (awvalid || wvalid);
        do @(posedge mclk_i); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [9:0] i);
        @(posedge mclk_i);
        araddr <= {i, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge mclk_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge mclk_i); while (rvalid !== 1'b1);
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
    endtask : rd
    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        cmp_count++;
        if (a !== e)
        begin
            $display("ERROR %0t: got %h expected %h", $time, a, e);
            fail_count++;
        end
    endtask : chk
    // ========================================
    // Scenarios
    task automatic t_reset;
        rd(sptb_pkg::IDX_SERIAL_CONTROL);
        chk(d, 8'h00);
        rd(sptb_pkg::IDX_SERIAL_BUFFER);
        chk(d, 8'h00);
        rd(10'h001);
        chk({6'h0, r}, 8'h02);
        wr(10'h001, 8'h11);
        chk({6'h0, r}, 8'h02);
        // Divisor 0x0011 gives 17 clocks per bit, matching the far-side device's L
        wr(sptb_pkg::IDX_T1L, 8'h11);
        wr(sptb_pkg::IDX_T1H, 8'h00);
        $display("test reset done");
    endtask : t_reset
    task automatic t_tx(input logic [1:0] m, input logic [7:0] v, input logic n9);
        wr(sptb_pkg::IDX_SERIAL_CONTROL, {m, 2'b00, n9, 3'b000});
        wr(sptb_pkg::IDX_SERIAL_BUFFER, v);
        repeat (12 * 17) @(posedge mclk_i);
        chk(got[7:0], v);
        chk({7'h0, got[8]}, (m == sptb_pkg::MODE_A11) ? {7'h0, n9} : 8'h01);
        rd(sptb_pkg::IDX_SERIAL_CONTROL);
        chk(d & 8'h02, 8'h02);
        wr(sptb_pkg::IDX_SERIAL_CONTROL, 8'h00);
        rd(sptb_pkg::IDX_SERIAL_CONTROL);
        chk(d, 8'h00);
        $display("test tx mode %b done", m);
    endtask : t_tx
    task automatic t_sync(input logic [7:0] v);
        logic [7:0] s;
        time        t;
        wr(sptb_pkg::IDX_SERIAL_CONTROL, 8'h00);
        wr(sptb_pkg::IDX_SERIAL_BUFFER, v);
        for (int k = 0; k < 8; k++)
        begin
            @(posedge txd);
            s[k] = rxd_line;
            chk({7'h0, oe_n}, 8'h00);
            if (k > 0) chk(8'(($time - t) / 10), 8'h0c);
            t = $time;
        end
        chk(s, v);
        repeat (12) @(posedge mclk_i);
        chk({7'h0, oe_n}, 8'h01);
        rd(sptb_pkg::IDX_SERIAL_CONTROL);
        chk(d, 8'h02);
        wr(sptb_pkg::IDX_SERIAL_CONTROL, 8'h00);
        $display("test sync tx done");
    endtask : t_sync
    task automatic t_rsv;
        wr(sptb_pkg::IDX_SERIAL_CONTROL, 8'h80);
        wr(sptb_pkg::IDX_SERIAL_BUFFER, 8'h55);
        repeat (40) @(posedge mclk_i) chk({7'h0, txd}, 8'h01);
        rd(sptb_pkg::IDX_SERIAL_CONTROL);
        chk(d, 8'h80);
        $display("test reserved mode done");
    endtask : t_rsv
    task automatic t_rx;
        wr(sptb_pkg::IDX_SERIAL_CONTROL, 8'hf0);
        u_sptb_serial_dev.send(9'h15a, 9);
        repeat (20) @(posedge mclk_i);
        rd(sptb_pkg::IDX_SERIAL_CONTROL);
        chk(d, 8'hf5);
        rd(sptb_pkg::IDX_SERIAL_BUFFER);
        chk(d, 8'h5a);
        wr(sptb_pkg::IDX_SERIAL_CONTROL, 8'hf0);
        u_sptb_serial_dev.send(9'h0c3, 9);
        repeat (20) @(posedge mclk_i);
        rd(sptb_pkg::IDX_SERIAL_CONTROL);
        chk(d, 8'hf0);
        wr(sptb_pkg::IDX_SERIAL_CONTROL, 8'h40);
        u_sptb_serial_dev.send(9'h077, 8);
        repeat (20) @(posedge mclk_i);
        rd(sptb_pkg::IDX_SERIAL_CONTROL);
        chk(d, 8'h40);
        rd(sptb_pkg::IDX_SERIAL_BUFFER);
        chk(d, 8'h5a);
        $display("test rx done");
    endtask : t_rx
    task automatic complete_run;
        $display("counts: %0d compares, %0d mismatches", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run
    initial
    begin
        forever #5 mclk_i = ~mclk_i;
    end
    // Whole run needs under 4000 cycles
    initial
    begin
        repeat (20000) @(posedge mclk_i);
        fail_count++;
        complete_run();
    end
    initial
    begin
        repeat (4) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        t_reset();
        t_tx(sptb_pkg::MODE_A10, 8'ha5, 1'b0);
        t_tx(sptb_pkg::MODE_A11, 8'h3c, 1'b1);
        t_sync(8'h96);
        t_rsv();
        t_rx();
        complete_run();
    end
endmodule : sptb_uart_bench
`default_nettype wire
